//--- core/sarseq_sar_adc_sequencer.v
// successive-approximation sequencer with its apb register file
// Operation
// - first trial keeps msb if input at/above half
// - after bit 9, trial bit 8, tap by bit9
// - keep trial bit if input at/above tap
// - 10-bit mode decides down to bit 0
// - 8-bit mode stops after bit 2
// - copy result into high and low registers
// - conversion end raises done request
// - high register holds top eight bits
// - low register: two lsbs on top, zeros
// - select one of seven channels or reference
// - clock-on low stops and resets converter
// - clock-on low clears regs, ignores writes
// - clock-on high allows register access
// - enable register resets zero, bit/byte writes
// - run bit self-clears at end, or by write
// - run write ignored while comparator off
// - resolution select picks last trial bit
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`include "sarseq_regs.vh"
module sarseq_sar_adc_sequencer (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire compareHigh,
  output reg [9:0] successiveApproxReg,
  output reg sampleHold,
  output reg comparatorOn,
  output reg converterClockOn,
  output reg [2:0] analogChannel,
  output reg referenceSelect,
  output reg conversionDoneIrq
);
  // ****************************************
  // overview
  // ****************************************
  // a conversion is started by software setting the run bit while the
  // comparator enable bit is already set; the sequencer then walks the
  // approximation register from bit 9 downward, one step per bit
  // each step lasts a fixed number of clocks from the step divider, so
  // the comparator has a settled input before its answer is taken
  // the trial code on successiveApproxReg doubles as the tap code that
  // the analog side turns into a comparison level
  // 8-bit mode stops after bit 2 and leaves bits 1 and 0 at zero
  // apart from the clock-on clear, the result bytes change only at the end of a finished conversion;
  // a software stop leaves the previous result readable
  // with the clock-on bit low every converter register is held at its
  // reset value, so a write made then is simply lost
  // the enable register itself stays writable, otherwise the block
  // could never be switched back on
  // bus timing: a setup phase latches read data, the next cycle is the
  // access phase with pready high; writes land at that access edge
  // limitation: only byte lane 0 is decoded, so narrower software
  // accesses must still place their data in the low byte
  // ****************************************
  // state
  // ****************************************
  localparam IDLE = 2'b00; // waiting for run
  localparam TRIAL = 2'b01; // bit trials in progress
  localparam DONE = 2'b10; // store result
  reg [1:0] state;
  reg [7:0] pce; // peripheral clock enable register
  reg [7:0] modeReg; // run and comparator enable
  reg resolutionSelect; // 1 picks 8-bit
  reg [7:0] channelSel; // channel select register
  reg [7:0] testReg; // test register, stored only
  reg [7:0] resultHigh;
  reg [7:0] resultLow;
  reg [3:0] bitIdx; // bit under trial
  wire clockOn;
  wire runBit;
  wire stepPulse;
  wire [7:0] packHigh;
  wire [7:0] packLow;
  wire wrAccess;
  wire rdAccess;
  wire [3:0] lastBit;
  reg [9:0] next_sar;
  // ****************************************
  // helpers
  // ****************************************
  // address decode used by both read and write paths
  function hitAddr;
    input [31:0] a;
    input [19:0] off;
    begin
      hitAddr = (a[31:20] == 12'h000) && (a[19:0] == off);
    end
  endfunction
  // applies byte lane 0 strobe; single-bit writes arrive as whole bytes
  function [7:0] laneByte;
    input [7:0] oldV;
    input [31:0] wd;
    input [3:0] st;
    begin
      laneByte = st[0] ? wd[7:0] : oldV;
    end
  endfunction
  assign clockOn = pce[`SARSEQ_PCE_CLKON];
  assign runBit = modeReg[`SARSEQ_MODE_RUN];
  assign wrAccess = psel && penable && pwrite && pready;
  assign rdAccess = psel && !pwrite;
  // 8-bit mode ends after bit 2, 10-bit after bit 0
  assign lastBit = resolutionSelect ? `SARSEQ_LAST_8 : `SARSEQ_LAST_10;
  // ****************************************
  // submodules
  // ****************************************
  sarseq_step_timer uTimer (
    .clk(clk),
    .nrst(nrst),
    .run(state == TRIAL),
    .stepPulse(stepPulse)
  );
  sarseq_result_pack uPack (
    .sarValue(successiveApproxReg),
    .highByte(packHigh),
    .lowByte(packLow)
  );
  // ****************************************
  // trial decision
  // ****************************************
  // keep trial bit on high compare, then set the next lower trial bit
  always @* begin
    next_sar = successiveApproxReg;
    if (!compareHigh) begin
      next_sar[bitIdx] = 1'b0;
    end
    if (bitIdx != lastBit) begin
      // next lower bit becomes the trial; the tap follows the decided bits
      next_sar[bitIdx - 4'h1] = 1'b1;
    end
  end
  // ****************************************
  // peripheral enable register
  // ****************************************
  // not gated by clock-on; resets to zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pce <= `SARSEQ_RST_BYTE;
    end else if (wrAccess && hitAddr(paddr, `SARSEQ_OFF_PCE)) begin
      // unused bits are software's duty; stored as written
      pce <= laneByte(pce, pwdata, pstrb);
    end
  end
  // ****************************************
  // converter registers and sequencer
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= IDLE;
      modeReg <= `SARSEQ_RST_BYTE;
      resolutionSelect <= 1'b0;
      channelSel <= `SARSEQ_RST_BYTE;
      testReg <= `SARSEQ_RST_BYTE;
      resultHigh <= `SARSEQ_RST_BYTE;
      resultLow <= `SARSEQ_RST_BYTE;
      successiveApproxReg <= `SARSEQ_RST_SAR;
      bitIdx <= `SARSEQ_TOP_BIT;
      conversionDoneIrq <= 1'b0;
    end else if (!clockOn) begin
      // held in reset, every write ignored
      state <= IDLE;
      modeReg <= `SARSEQ_RST_BYTE;
      resolutionSelect <= 1'b0;
      channelSel <= `SARSEQ_RST_BYTE;
      testReg <= `SARSEQ_RST_BYTE;
      resultHigh <= `SARSEQ_RST_BYTE;
      resultLow <= `SARSEQ_RST_BYTE;
      successiveApproxReg <= `SARSEQ_RST_SAR;
      bitIdx <= `SARSEQ_TOP_BIT;
      conversionDoneIrq <= 1'b0;
    end else begin
      conversionDoneIrq <= 1'b0;
      // register writes, allowed with the clock on
      if (wrAccess && hitAddr(paddr, `SARSEQ_OFF_MODE)) begin
        modeReg[`SARSEQ_MODE_CMPEN] <= pwdata[`SARSEQ_MODE_CMPEN] & pstrb[0];
        modeReg[4:3] <= pwdata[4:3];
        // run can only be set while the comparator is already on
        if (!pwdata[`SARSEQ_MODE_RUN] || !pstrb[0]) begin
          modeReg[`SARSEQ_MODE_RUN] <= 1'b0;
        end else if (modeReg[`SARSEQ_MODE_CMPEN]) begin
          modeReg[`SARSEQ_MODE_RUN] <= 1'b1;
        end else begin
          modeReg[`SARSEQ_MODE_RUN] <= 1'b0;
        end
      end
      if (wrAccess && hitAddr(paddr, `SARSEQ_OFF_RES) && pstrb[0]) begin
        resolutionSelect <= pwdata[`SARSEQ_RES_SEL];
      end
      if (wrAccess && hitAddr(paddr, `SARSEQ_OFF_CHAN) && pstrb[0]) begin
        channelSel <= pwdata[7:0] & `SARSEQ_CHAN_MASK;
      end
      if (wrAccess && hitAddr(paddr, `SARSEQ_OFF_TEST) && pstrb[0]) begin
        testReg <= pwdata[7:0] & `SARSEQ_TEST_MASK;
      end
      // sequencer
      case (state)
        IDLE: begin
          if (runBit) begin
            successiveApproxReg <= 10'h200;
            bitIdx <= `SARSEQ_TOP_BIT;
            state <= TRIAL;
          end
        end
        TRIAL: begin
          if (!runBit) begin
            // software stop abandons the conversion
            state <= IDLE;
          end else if (stepPulse) begin
            successiveApproxReg <= next_sar;
            if (bitIdx == lastBit) begin
              state <= DONE;
            end else begin
              bitIdx <= bitIdx - 4'h1;
            end
          end
        end
        DONE: begin
          resultHigh <= packHigh;
          resultLow <= packLow;
          conversionDoneIrq <= 1'b1;
          modeReg[`SARSEQ_MODE_RUN] <= 1'b0;
          state <= IDLE;
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end
  // ****************************************
  // analog side outputs, registered
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sampleHold <= 1'b0;
      comparatorOn <= 1'b0;
      converterClockOn <= 1'b0;
      analogChannel <= 3'h0;
      referenceSelect <= 1'b0;
    end else begin
      // hold the sample through every trial
      sampleHold <= clockOn && (state == TRIAL);
      comparatorOn <= clockOn && modeReg[`SARSEQ_MODE_CMPEN];
      converterClockOn <= clockOn;
      // codes 0..6 pick a pin, 7 picks the internal reference
      analogChannel <= channelSel[2:0];
      referenceSelect <= (channelSel[3:0] == `SARSEQ_CHAN_MAX)
        ? 1'b1 : 1'b0;
    end
  end
  // ****************************************
  // apb slave: no wait states, zero on unmapped read
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      // ready answers the setup cycle; a setup that follows an access at
      // once is seen with penable low again, so it gets its own ready
      // read data is captured at setup so it stands through the access
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (rdAccess && !penable) begin
        if (hitAddr(paddr, `SARSEQ_OFF_PCE)) begin
          prdata <= {24'h000000, pce};
        end else if (hitAddr(paddr, `SARSEQ_OFF_MODE)) begin
          prdata <= {24'h000000, modeReg & `SARSEQ_MODE_MASK};
        end else if (hitAddr(paddr, `SARSEQ_OFF_RES)) begin
          prdata <= {31'h00000000, resolutionSelect};
        end else if (hitAddr(paddr, `SARSEQ_OFF_CHAN)) begin
          prdata <= {24'h000000, channelSel};
        end else if (hitAddr(paddr, `SARSEQ_OFF_TEST)) begin
          prdata <= {24'h000000, testReg};
        end else if (hitAddr(paddr, `SARSEQ_OFF_RHIGH)) begin
          prdata <= {24'h000000, resultHigh};
        end else if (hitAddr(paddr, `SARSEQ_OFF_RLOW)) begin
          prdata <= {24'h000000, resultLow};
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end
endmodule

//--- include/sarseq_regs.vh
// register offsets, field positions, reset values and timing for the sar sequencer
`ifndef SARSEQ_REGS_VH
`define SARSEQ_REGS_VH
// ****************************************
// register byte addresses (apb, one word each)
// ****************************************
`define SARSEQ_OFF_PCE 20'hf00f0
`define SARSEQ_OFF_MODE 20'hfff30
`define SARSEQ_OFF_RES 20'hf0010
`define SARSEQ_OFF_CHAN 20'hfff34
`define SARSEQ_OFF_TEST 20'hfff38
`define SARSEQ_OFF_RHIGH 20'hfff3c
`define SARSEQ_OFF_RLOW 20'hfff40
`define SARSEQ_ADDR_W 20
// ****************************************
// field positions
// ****************************************
`define SARSEQ_PCE_CLKON 5
`define SARSEQ_MODE_RUN 7
`define SARSEQ_MODE_CMPEN 0
`define SARSEQ_RES_SEL 0
// mode bits 1,2,5,6 are fixed zero
`define SARSEQ_MODE_MASK 8'h99
`define SARSEQ_CHAN_MASK 8'h0f
`define SARSEQ_TEST_MASK 8'h03
// ****************************************
// reset values
// ****************************************
`define SARSEQ_RST_BYTE 8'h00
`define SARSEQ_RST_SAR 10'h000
// ****************************************
// sizes and timing
// ****************************************
`define SARSEQ_SAR_W 10
`define SARSEQ_TOP_BIT 4'h9
`define SARSEQ_LAST_10 4'h0
`define SARSEQ_LAST_8 4'h2
// cycles that each trial waits for the comparator to settle
`define SARSEQ_STEP_CYCLES 8'h04
`define SARSEQ_CHAN_MAX 4'h7
`endif

//--- core/sarseq_step_timer.v
// step enable divider: one-cycle pulse per sequencer step
`timescale 1ns/10ps
`include "sarseq_regs.vh"
module sarseq_step_timer (
  input wire clk,
  input wire nrst,
  input wire run,
  output reg stepPulse
);
  reg [7:0] count; // cycles into current step
  // ****************************************
  // divider
  // ****************************************
  // restarts whenever run drops, so every trial gets a full settle time
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= 8'h00;
      stepPulse <= 1'b0;
    end else if (!run) begin
      count <= 8'h00;
      stepPulse <= 1'b0;
    end else if (count == `SARSEQ_STEP_CYCLES - 8'h01) begin
      count <= 8'h00;
      stepPulse <= 1'b1;
    end else begin
      count <= count + 8'h01;
      stepPulse <= 1'b0;
    end
  end
endmodule

//--- core/sarseq_result_pack.v
// packs the approximation register into the two result bytes
`timescale 1ns/10ps
`include "sarseq_regs.vh"
module sarseq_result_pack (
  input wire [9:0] sarValue,
  output wire [7:0] highByte,
  output wire [7:0] lowByte
);
  // upper eight bits of the result
  assign highByte = sarValue[9:2];
  // two lowest bits on top, six low positions tied to zero
  assign lowByte = {sarValue[1:0], 6'b000000};
endmodule

//--- tb/sarseq_chk.sv
// concurrent checks on the sar sequencer ports
`timescale 1ns/10ps
module sarseq_chk (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire [9:0] successiveApproxReg,
  input wire sampleHold,
  input wire comparatorOn,
  input wire converterClockOn,
  input wire conversionDoneIrq
);
  // ****************************************
  // one clock domain, reset masks all checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_done_pulse: assert property (conversionDoneIrq |=> !conversionDoneIrq)
    else $error("done request longer than one cycle");
  a_done_after: assert property (conversionDoneIrq |-> $past(sampleHold))
    else $error("done request without trials");
  a_start_top: assert property ($rose(sampleHold) |-> successiveApproxReg == 10'h200)
    else $error("first trial not the top bit");
  // a step is four cycles, so a trial code must stand three more
  a_step_hold: assert property (sampleHold && $changed(successiveApproxReg)
    |=> (!sampleHold || $stable(successiveApproxReg))[*3])
    else $error("trial code changed inside a step");
  a_off_idle: assert property (!converterClockOn && !$past(converterClockOn)
    |-> !sampleHold && !comparatorOn)
    else $error("converter active with clock off");
  a_comp_gate: assert property (comparatorOn |-> converterClockOn)
    else $error("comparator on without clock");
  a_run_needs: assert property (sampleHold |-> comparatorOn)
    else $error("trials run with comparator off");
endmodule
bind sarseq_sar_adc_sequencer sarseq_chk chk (
  .clk(clk),
  .nrst(nrst),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .successiveApproxReg(successiveApproxReg),
  .sampleHold(sampleHold),
  .comparatorOn(comparatorOn),
  .converterClockOn(converterClockOn),
  .conversionDoneIrq(conversionDoneIrq)
);

//--- tb/sarseq_cmp_model.sv
// comparator model: held input as a code against the trial tap code
`timescale 1ns/10ps
module sarseq_cmp_model (
  input wire clk,
  input wire sampleHold,
  input wire [9:0] tapCode,
  input wire [9:0] vin,
  output wire compareHigh
);
  // last answer, kept so an idle output never repeats it
  logic last = 1'h0;
  always @(posedge clk) begin
    if (sampleHold) begin
      last <= compareHigh;
    end
  end
  // at or above the tap reads high; idle shows the inverse of the last
  assign compareHigh = sampleHold ? (vin >= tapCode) : ~last;
endmodule

//--- tb/tb_sar_adc_sequencer.sv
// self-checking bench for the sar sequencer
`timescale 1ns/10ps
`include "sarseq_regs.vh"
module tb_sar_adc_sequencer;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] vin = 10'h000; // held input level as a code
  logic [31:0] rd; // last read word
  wire [31:0] prdata;
  wire [9:0] successiveApproxReg;
  wire [2:0] analogChannel;
  wire pready, pslverr, compareHigh, sampleHold, comparatorOn, converterClockOn;
  wire referenceSelect, conversionDoneIrq;
  int errors = 0;
  int samplesChecked = 0;
  // rows: {resolution, input code, high byte, low byte}
  logic [26:0] rows [6] = '{{1'h0, 10'h3ff, 8'hff, 8'hc0}, {1'h0, 10'h000, 8'h00, 8'h00},
    {1'h0, 10'h201, 8'h80, 8'h40}, {1'h0, 10'h1fe, 8'h7f, 8'h80},
    {1'h1, 10'h3ff, 8'hff, 8'h00}, {1'h1, 10'h155, 8'h55, 8'h00}};
  always #2 clk = ~clk;
  sarseq_sar_adc_sequencer uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .compareHigh(compareHigh),
    .successiveApproxReg(successiveApproxReg), .sampleHold(sampleHold),
    .comparatorOn(comparatorOn),
    .converterClockOn(converterClockOn), .analogChannel(analogChannel),
    .referenceSelect(referenceSelect), .conversionDoneIrq(conversionDoneIrq));
  sarseq_cmp_model cmp (.clk(clk), .sampleHold(sampleHold), .tapCode(successiveApproxReg),
    .vin(vin), .compareHigh(compareHigh));
  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task xfer(input logic wr, input logic [19:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {12'h000, a};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rd = prdata;
    chk("pready", {31'h0, pready}, 32'h1);
    chk("pslverr", {31'h0, pslverr}, 32'h0);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    xfer(1'h0, `SARSEQ_OFF_PCE, 8'h00);
    chk("pce reset", rd, 32'h0);
    xfer(1'h1, `SARSEQ_OFF_PCE, 8'h20);
    xfer(1'h0, `SARSEQ_OFF_PCE, 8'h00);
    chk("pce set", rd, 32'h20);
    xfer(1'h1, `SARSEQ_OFF_MODE, 8'h80);
    xfer(1'h0, `SARSEQ_OFF_MODE, 8'h00);
    chk("run refused", rd, 32'h0);
    xfer(1'h1, `SARSEQ_OFF_MODE, 8'h01);
    repeat (2) @(posedge clk);
    chk("comparator on", {31'h0, comparatorOn}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      int n;
      vin <= rows[i][25:16];
      xfer(1'h1, `SARSEQ_OFF_RES, {7'h00, rows[i][26]});
      xfer(1'h1, `SARSEQ_OFF_MODE, 8'h81);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (conversionDoneIrq !== 1'h1 && n < 100);
      chk("done irq", {31'h0, conversionDoneIrq}, 32'h1);
      xfer(1'h0, `SARSEQ_OFF_RHIGH, 8'h00);
      chk("result high", rd, {24'h0, rows[i][15:8]});
      xfer(1'h0, `SARSEQ_OFF_RLOW, 8'h00);
      chk("result low", rd, {24'h0, rows[i][7:0]});
      xfer(1'h0, `SARSEQ_OFF_MODE, 8'h00);
      chk("run cleared", rd, 32'h1);
      $display("row %0d done", i);
    end
    // software stop mid-run leaves the old result in place
    vin <= 10'h3ff;
    xfer(1'h1, `SARSEQ_OFF_MODE, 8'h81);
    repeat (8) @(posedge clk);
    xfer(1'h1, `SARSEQ_OFF_MODE, 8'h01);
    repeat (3) @(posedge clk);
    chk("stopped", {31'h0, sampleHold}, 32'h0);
    xfer(1'h0, `SARSEQ_OFF_RHIGH, 8'h00);
    chk("result kept", rd, 32'h55);
    xfer(1'h1, `SARSEQ_OFF_CHAN, 8'h07);
    repeat (2) @(posedge clk);
    chk("reference", {31'h0, referenceSelect}, 32'h1);
    xfer(1'h1, `SARSEQ_OFF_CHAN, 8'h03);
    repeat (2) @(posedge clk);
    chk("channel", {28'h0, referenceSelect, analogChannel}, 32'h3);
    xfer(1'h0, 20'h00004, 8'h00);
    chk("unmapped", rd, 32'h0);
    // clock off: registers back to reset, writes dropped
    xfer(1'h1, `SARSEQ_OFF_PCE, 8'h00);
    repeat (2) @(posedge clk);
    chk("clock on", {31'h0, converterClockOn}, 32'h0);
    chk("comparator off", {31'h0, comparatorOn}, 32'h0);
    xfer(1'h1, `SARSEQ_OFF_MODE, 8'h01);
    xfer(1'h0, `SARSEQ_OFF_MODE, 8'h00);
    chk("mode gated", rd, 32'h0);
    xfer(1'h0, `SARSEQ_OFF_RHIGH, 8'h00);
    chk("high gated", rd, 32'h0);
    // reset in mid-conversion: everything back to zero, enable register too
    xfer(1'h1, `SARSEQ_OFF_PCE, 8'h20);
    xfer(1'h1, `SARSEQ_OFF_MODE, 8'h01);
    xfer(1'h1, `SARSEQ_OFF_MODE, 8'h81);
    repeat (6) @(posedge clk);
    chk("running", {31'h0, sampleHold}, 32'h1);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    chk("reset hold", {31'h0, sampleHold}, 32'h0);
    chk("reset clock", {31'h0, converterClockOn}, 32'h0);
    chk("reset sar", {22'h0, successiveApproxReg}, 32'h0);
    nrst <= 1'h1;
    xfer(1'h0, `SARSEQ_OFF_PCE, 8'h00);
    chk("pce after reset", rd, 32'h0);
    $display("hand tests done");
    close_out;
  end
  // hang guard, far beyond six conversions
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    close_out;
  end
endmodule
